// ===== mrsi_pkg.sv
// Notes on behaviour
// - while the reset pin is low, hold everything in reset with defined register values.
// - when the reset pin returns high, leave reset and run from the reset vector.
// - with internal program memory, the first prefetch starts 11 states after release.
// - with external program memory, the first prefetch starts 41 states after release.
// - one state is one system clock period, 167 ns at 6 MHz; the code counts CYC_PER_STATE (34) cycles of the 5 ns clock per state.
// - reset clears program counter, status word and cpu control word to zero.
// - reset sets all port direction registers to ones; output latches stay undefined.
// - reset loads both port function control registers with low nibble set.
// - reset clears count, capture, pwm, timer control and adc mode registers.
// - reset clears serial mode, serial control and baud setting; buffers stay undefined.
// - reset clears the time base counter, time base mode and watchdog mode registers.
// - reset loads the memory expansion mode register with 30h.
// - reset loads the psram refresh mode register with 10h.
// - reset clears irq mode and in-service priority; irq control registers get 47h.
// - reset puts 2 in the standby control upper nibble and leaves bit 3 alone.
// - reset out of standby keeps internal ram and general registers intact.
// - data registers such as stack pointer and ram are never initialised by reset.
package mrsi_pkg;
    localparam int REG_COUNT    = 44;
    localparam int IDX_W        = 6;
    localparam int IDX_CPU_CTRL       = 0;
    localparam int IDX_PORT_DIR_FIRST = 1;
    localparam int IDX_PORT_DIR_LAST  = 5;
    localparam int IDX_PORT2_FN       = 6;
    localparam int IDX_PORT3_FN       = 7;
    localparam int IDX_RT_PORT        = 15;
    localparam int IDX_STANDBY        = 23;
    localparam int IDX_MEM_EXP        = 25;
    localparam int IDX_REFRESH        = 26;
    localparam int IRQ_FIRST          = 29;
    localparam int IRQ_LAST           = 43;
    localparam int STANDBY_KEEP_BIT   = 3;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [7:0]  VAL_ZERO     = 8'h00;
    localparam logic [7:0]  VAL_PORT_DIR = 8'hff;
    localparam logic [7:0]  VAL_PORT_FN  = 8'h0f;
    localparam logic [7:0]  VAL_RT_PORT  = 8'h08;
    localparam logic [7:0]  VAL_STANDBY  = 8'h20;
    localparam logic [7:0]  VAL_MEM_EXP  = 8'h30;
    localparam logic [7:0]  VAL_REFRESH  = 8'h10;
    localparam logic [7:0]  VAL_IRQ_CTRL = 8'h47;
    localparam int STATE_NS      = 167;
    localparam int CLK_NS        = 5;
    localparam int CYC_PER_STATE = (STATE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROM_STATES    = 11;
    localparam int EXT_STATES    = 41;
    localparam int ROM_CYCLES    = ROM_STATES * CYC_PER_STATE;
    localparam int EXT_CYCLES    = EXT_STATES * CYC_PER_STATE;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_WAIT  = 3'b010,
        ST_RUN   = 3'b100
    } mrsi_state_type;

    function automatic logic [7:0] reg_reset(input int idx);
        if (idx >= IDX_PORT_DIR_FIRST && idx <= IDX_PORT_DIR_LAST)
            return VAL_PORT_DIR;
        else if (idx == IDX_PORT2_FN || idx == IDX_PORT3_FN)
            return VAL_PORT_FN;
        else if (idx == IDX_RT_PORT)
            return VAL_RT_PORT;
        else if (idx == IDX_STANDBY)
            return VAL_STANDBY;
        else if (idx == IDX_MEM_EXP)
            return VAL_MEM_EXP;
        else if (idx == IDX_REFRESH)
            return VAL_REFRESH;
        else if (idx >= IRQ_FIRST && idx <= IRQ_LAST)
            return VAL_IRQ_CTRL;
        else
            return VAL_ZERO;
    endfunction
endpackage

// ===== mrsi_reset_init.sv
`timescale 1ns/1ps
module mrsi_reset_init #(
    parameter int TBC_W = 13,
    parameter int GP_COUNT = 16
) (
    // clock and system
    input  wire logic                          i_clk,
    input  wire logic                          i_clk_en,
    input  wire logic                          i_reset_n,
    // reset pin and fetch source
    input  wire logic                          i_reset_pin_n,
    input  wire logic                          i_ext_fetch,
    // register write port
    input  wire logic                          i_wr_en,
    input  wire logic [mrsi_pkg::IDX_W-1:0]    i_wr_idx,
    input  wire logic [7:0]                    i_wr_data,
    // general register write and read port
    input  wire logic                          i_gp_wr,
    input  wire logic [$clog2(GP_COUNT)-1:0]   i_gp_idx,
    input  wire logic [7:0]                    i_gp_data,
    output logic      [7:0]                    o_gp_rdata,
    // status
    output logic                               o_in_reset,
    output logic                               o_running,
    output logic                               o_prefetch_start,
    output logic      [15:0]                   o_pc,
    output logic      [15:0]                   o_psw,
    output logic      [TBC_W-1:0]              o_time_base,
    output logic      [mrsi_pkg::REG_COUNT*8-1:0] o_regs
);
    localparam int PRE_W = $clog2(mrsi_pkg::CYC_PER_STATE + 1);
    localparam int CNT_W = $clog2(mrsi_pkg::EXT_STATES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(mrsi_pkg::CYC_PER_STATE - 1);
    localparam logic [CNT_W-1:0] ROM_LAST = CNT_W'(mrsi_pkg::ROM_STATES - 1);
    localparam logic [CNT_W-1:0] EXT_LAST = CNT_W'(mrsi_pkg::EXT_STATES - 1);

    logic [1:0]               pin_sync;
    logic                     pin_low;
    mrsi_pkg::mrsi_state_type state;
    logic [PRE_W-1:0]         pre_cnt;
    logic [CNT_W-1:0]         state_cnt;
    logic                     state_tick;
    logic                     ext_sel;
    logic                     wait_done;
    logic [7:0]               gp_regs [GP_COUNT];
    logic [PRE_W-1:0]         run_pre;
    logic                     state_tick_run;
    logic                     gp_seen;

    // assertion is immediate so a glitch-free hold is seen at once; release waits two edges
    always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
        if (!i_reset_pin_n) begin
            pin_sync <= 2'b00;
        end else if (i_clk_en) begin
            pin_sync <= {pin_sync[0], 1'b1};
        end
    end

    assign pin_low    = !pin_sync[1];
    assign state_tick = (pre_cnt == PRE_LAST);
    assign wait_done  = state_tick && (state_cnt == (ext_sel ? EXT_LAST : ROM_LAST));

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= mrsi_pkg::ST_RESET;
        end else if (i_clk_en) begin
            case (state)
                mrsi_pkg::ST_RESET: begin
                    if (!pin_low)
                        state <= mrsi_pkg::ST_WAIT;
                end
                mrsi_pkg::ST_WAIT: begin
                    if (pin_low)
                        state <= mrsi_pkg::ST_RESET;
                    else if (wait_done)
                        state <= mrsi_pkg::ST_RUN;
                end
                mrsi_pkg::ST_RUN: begin
                    if (pin_low)
                        state <= mrsi_pkg::ST_RESET;
                end
                default: state <= mrsi_pkg::ST_RESET;
            endcase
        end
    end

    // one state is a fixed number of system clocks
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pre_cnt   <= '0;
            state_cnt <= '0;
            ext_sel   <= 1'b0;
        end else if (i_clk_en) begin
            if (state != mrsi_pkg::ST_WAIT) begin
                pre_cnt   <= '0;
                state_cnt <= '0;
                ext_sel   <= i_ext_fetch; // fetch source sampled up to the release
            end else if (state_tick) begin
                pre_cnt   <= '0;
                state_cnt <= state_cnt + 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_in_reset       <= 1'b1;
            o_running        <= 1'b0;
            o_prefetch_start <= 1'b0;
        end else if (i_clk_en) begin
            o_in_reset       <= pin_low || (state == mrsi_pkg::ST_RESET);
            o_running        <= !pin_low && (state == mrsi_pkg::ST_RUN || (state == mrsi_pkg::ST_WAIT && wait_done));
            o_prefetch_start <= !pin_low && state == mrsi_pkg::ST_WAIT && wait_done;
        end
    end

    // program counter and status word sit at the reset vector until the core takes over
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_clk_en && pin_low)) begin
            o_pc  <= mrsi_pkg::PC_RESET;
            o_psw <= mrsi_pkg::STATUS_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_clk_en && pin_low)) begin
            o_time_base <= '0;
        end else if (i_clk_en && state == mrsi_pkg::ST_RUN && state_tick_run) begin
            o_time_base <= o_time_base + 1'b1;
        end
    end

    // time base advances once per state while running
    assign state_tick_run = (run_pre == PRE_LAST);
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_clk_en && state != mrsi_pkg::ST_RUN)) begin
            run_pre <= '0;
        end else if (i_clk_en) begin
            run_pre <= state_tick_run ? '0 : run_pre + 1'b1;
        end
    end

    // control registers; the standby bit that survives reset is merged back in
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_clk_en && pin_low)) begin
            for (int i = 0; i < mrsi_pkg::REG_COUNT; i++) begin
                o_regs[i*8 +: 8] <= mrsi_pkg::reg_reset(i);
            end
            // the pin leaves the standby bit alone; only the power-up system reset gives it a defined value
            o_regs[mrsi_pkg::IDX_STANDBY*8 + mrsi_pkg::STANDBY_KEEP_BIT] <= i_reset_n
                ? o_regs[mrsi_pkg::IDX_STANDBY*8 + mrsi_pkg::STANDBY_KEEP_BIT] : 1'b0;
        end else if (i_clk_en && i_wr_en && state == mrsi_pkg::ST_RUN
                     && int'(i_wr_idx) < mrsi_pkg::REG_COUNT) begin
            o_regs[int'(i_wr_idx)*8 +: 8] <= i_wr_data;
        end
    end

    // general registers have no reset so standby contents live through it
    always_ff @(posedge i_clk) begin
        if (i_clk_en && i_gp_wr && state == mrsi_pkg::ST_RUN) begin
            gp_regs[i_gp_idx] <= i_gp_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            o_gp_rdata <= gp_regs[i_gp_idx];
        end
    end

    // helper: enabled cycles spent waiting since release
    logic [15:0] wait_cycles;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_clk_en && state != mrsi_pkg::ST_WAIT)) begin
            wait_cycles <= '0;
        end else if (i_clk_en) begin
            wait_cycles <= wait_cycles + 1'b1;
        end
    end

    // helper: word 0 holds software data, so its retention across reset can be watched
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            gp_seen <= 1'b0;
        end else if (i_clk_en && i_gp_wr && state == mrsi_pkg::ST_RUN && i_gp_idx == '0) begin
            gp_seen <= 1'b1;
        end
    end

    property p_hold_reset;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && pin_low) |=> (o_in_reset && state == mrsi_pkg::ST_RESET && !o_running);
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("reset pin low did not hold reset");

    property p_release;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_RESET && !pin_low) |=> state == mrsi_pkg::ST_WAIT;
    endproperty
    a_release: assert property (p_release) else $error("release did not start the wait");

    property p_rom_prefetch;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_prefetch_start && !ext_sel) |-> wait_cycles == 16'(mrsi_pkg::ROM_CYCLES);
    endproperty
    a_rom_prefetch: assert property (p_rom_prefetch) else $error("internal fetch start not at 11 states");

    property p_ext_prefetch;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_prefetch_start && ext_sel) |-> wait_cycles == 16'(mrsi_pkg::EXT_CYCLES);
    endproperty
    a_ext_prefetch: assert property (p_ext_prefetch) else $error("external fetch start not at 41 states");

    property p_state_len;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_WAIT && state_tick && !pin_low) |=> pre_cnt == '0;
    endproperty
    a_state_len: assert property (p_state_len) else $error("state length counter did not wrap");

    property p_cpu_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(state == mrsi_pkg::ST_WAIT) |-> (o_pc == '0 && o_psw == '0 && o_regs[mrsi_pkg::IDX_CPU_CTRL*8 +: 8] == '0);
    endproperty
    a_cpu_zero: assert property (p_cpu_zero) else $error("cpu words not cleared at release");

    property p_port_values;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && pin_low) |=> (o_regs[mrsi_pkg::IDX_PORT_DIR_FIRST*8 +: 8] == mrsi_pkg::VAL_PORT_DIR
            && o_regs[mrsi_pkg::IDX_PORT3_FN*8 +: 8] == mrsi_pkg::VAL_PORT_FN);
    endproperty
    a_port_values: assert property (p_port_values) else $error("port registers wrong after reset");

    property p_mem_values;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && pin_low) |=> (o_regs[mrsi_pkg::IDX_MEM_EXP*8 +: 8] == mrsi_pkg::VAL_MEM_EXP
            && o_regs[mrsi_pkg::IDX_REFRESH*8 +: 8] == mrsi_pkg::VAL_REFRESH
            && o_regs[mrsi_pkg::IRQ_LAST*8 +: 8] == mrsi_pkg::VAL_IRQ_CTRL);
    endproperty
    a_mem_values: assert property (p_mem_values) else $error("memory or irq registers wrong after reset");

    property p_standby_ctrl_reg_keep;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && pin_low) |=> (o_regs[mrsi_pkg::IDX_STANDBY*8 + 4 +: 4] == mrsi_pkg::VAL_STANDBY[7:4]
            && $stable(o_regs[mrsi_pkg::IDX_STANDBY*8 + mrsi_pkg::STANDBY_KEEP_BIT]));
    endproperty
    a_standby_ctrl_reg_keep: assert property (p_standby_ctrl_reg_keep) else $error("standby control bit 3 changed by reset");

    property p_gp_keep;
        @(posedge i_clk) disable iff (!i_reset_n)
        (gp_seen && state == mrsi_pkg::ST_RESET) |=> $stable(gp_regs[0]);
    endproperty
    a_gp_keep: assert property (p_gp_keep) else $error("general register changed during reset");

    property p_wr_refused;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && i_wr_en && state != mrsi_pkg::ST_RUN) |=> $stable(o_regs);
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("register write accepted outside run");

    property p_pulse_once;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && o_prefetch_start) |=> !o_prefetch_start;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("prefetch start longer than one cycle");

    property p_run_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && o_running && !pin_low) |=> o_running;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("running dropped without reset");

    property p_wait_quiet;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_WAIT && !wait_done) |=> (!o_running && !o_prefetch_start);
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("fetch started before the state count");

    property p_in_reset_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_RUN && !pin_low) |=> !o_in_reset;
    endproperty
    a_in_reset_clear: assert property (p_in_reset_clear) else $error("reset flag high while running");

    property p_fetch_src_held;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_WAIT) |=> $stable(ext_sel);
    endproperty
    a_fetch_src_held: assert property (p_fetch_src_held) else $error("fetch source changed while waiting");

    property p_time_base_step;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clk_en && state == mrsi_pkg::ST_RUN && state_tick_run && !pin_low)
            |=> o_time_base == TBC_W'($past(o_time_base) + 1'b1);
    endproperty
    a_time_base_step: assert property (p_time_base_step) else $error("time base did not step once per state");

    c_rom_boot: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_prefetch_start && !ext_sel);
    c_ext_boot: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_prefetch_start && ext_sel);
    c_rereset:  cover property (@(posedge i_clk) disable iff (!i_reset_n) o_running ##1 o_in_reset);
    c_frozen:   cover property (@(posedge i_clk) disable iff (!i_reset_n) !i_clk_en && state == mrsi_pkg::ST_WAIT);
    c_keep_bit: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        o_in_reset && o_regs[mrsi_pkg::IDX_STANDBY*8 + mrsi_pkg::STANDBY_KEEP_BIT]);
endmodule

// ===== mrsi_dummy_never.sv
`timescale 1ns/1ps

// ===== mrsi_reset_source.sv
`timescale 1ns/1ps
module mrsi_reset_source #(
    parameter int HOLD_CYCLES = 8
) (
    // clock
    input  wire logic i_clk,
    // request from the bench
    input  wire logic i_assert,
    // reset pin
    output logic      o_reset_pin_n
);
    int hold_count;

    initial begin
        o_reset_pin_n = 1'b0;
        hold_count    = 0;
    end

    // settling time is scaled down; an early release request still waits it out
    always @(negedge i_clk) begin
        if (i_assert) begin
            o_reset_pin_n <= 1'b0;
            hold_count    <= 0;
        end else if (hold_count < HOLD_CYCLES) begin
            o_reset_pin_n <= 1'b0;
            hold_count    <= hold_count + 1;
        end else begin
            o_reset_pin_n <= 1'b1;
        end
    end
endmodule

// ===== tb_mcu_reset_state_init.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_mcu_reset_state_init;
    localparam int CYC = (167 + 4) / 5;
    logic         i_clk, i_clk_en, i_reset_n, i_reset_pin_n, i_ext_fetch, rst_req;
    logic         i_wr_en, i_gp_wr;
    logic [5:0]   i_wr_idx;
    logic [7:0]   i_wr_data, i_gp_data, o_gp_rdata;
    logic [3:0]   i_gp_idx;
    logic         o_in_reset, o_running, o_prefetch_start;
    logic [15:0]  o_pc, o_psw;
    logic [12:0]  o_time_base;
    logic [351:0] o_regs, snap;
    int           n_errors, samples_checked, cycles, i;

    mrsi_reset_source u_src (.i_clk(i_clk), .i_assert(rst_req), .o_reset_pin_n(i_reset_pin_n));

    mrsi_reset_init u_dut (
        .i_clk(i_clk), .i_clk_en(i_clk_en), .i_reset_n(i_reset_n), .i_reset_pin_n(i_reset_pin_n),
        .i_ext_fetch(i_ext_fetch), .i_wr_en(i_wr_en), .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data),
        .i_gp_wr(i_gp_wr), .i_gp_idx(i_gp_idx), .i_gp_data(i_gp_data), .o_gp_rdata(o_gp_rdata),
        .o_in_reset(o_in_reset), .o_running(o_running), .o_prefetch_start(o_prefetch_start),
        .o_pc(o_pc), .o_psw(o_psw), .o_time_base(o_time_base), .o_regs(o_regs)
    );

    function automatic logic [7:0] exp_byte(input int k);
        if (k >= 1 && k <= 5) return 8'hff;
        if (k == 6 || k == 7) return 8'h0f;
        if (k == 15) return 8'h08;
        if (k == 25) return 8'h30;
        if (k == 26) return 8'h10;
        if (k >= 29) return 8'h47;
        return 8'h00;
    endfunction

    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // a gap cycle after each write keeps the strobe from being raised twice in one step
    task automatic write_reg(input logic [5:0] idx, input logic [7:0] data);
        i_wr_en   = 1'b1;
        i_wr_idx  = idx;
        i_wr_data = data;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic read_gp(input logic [3:0] idx, input logic [7:0] exp);
        i_gp_idx = idx;
        @(negedge i_clk);
        `CHECK(o_gp_rdata, exp)
    endtask

    task automatic check_reset_state();
        for (int k = 0; k < 44; k++)
            if (k == 23) begin
                `CHECK(o_regs[k*8+4+:4], 4'h2)
                `CHECK(o_regs[k*8+:3], 3'h0)
            end else `CHECK(o_regs[k*8+:8], exp_byte(k))
        `CHECK(o_pc, 16'h0000)
        `CHECK(o_psw, 16'h0000)
        `CHECK(o_time_base, 13'h0000)
        `CHECK(o_in_reset, 1'b1)
        `CHECK(o_running, 1'b0)
    endtask

    // counts edges from the pin rising to the prefetch pulse, with an optional clock-enable gap
    task automatic release_and_time(input logic ext, input int freeze, input int expect_n);
        int n;
        i_ext_fetch = ext;
        rst_req <= 1'b0;
        @(posedge i_reset_pin_n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
            i_clk_en = !(n >= 100 && n < 100 + freeze);
        end while (o_prefetch_start !== 1'b1 && n < 3000);
        `CHECK(n, expect_n + freeze)
        `CHECK(o_running, 1'b1)
        `CHECK(o_in_reset, 1'b0)
        @(negedge i_clk);
        `CHECK(o_prefetch_start, 1'b0)
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        n_errors = 0; samples_checked = 0; cycles = 0;
        i_clk_en = 1'b1; i_reset_n = 1'b0; rst_req = 1'b1; i_ext_fetch = 1'b0;
        i_wr_en = 1'b0; i_wr_idx = 6'h00; i_wr_data = 8'h00;
        i_gp_wr = 1'b0; i_gp_idx = 4'h0; i_gp_data = 8'h00;
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        check_reset_state();
        write_reg(6'h08, 8'hc3);
        `CHECK(o_regs[8*8+:8], 8'h00)
        release_and_time(1'b0, 0, 3 + 11 * CYC);
        // scribble over every control byte so the next reset has something to restore
        for (i = 0; i < 44; i++) begin
            write_reg(i[5:0], (i == 23) ? 8'h08 : ~exp_byte(i));
            `CHECK(o_regs[i*8+:8], (i == 23) ? 8'h08 : ~exp_byte(i))
        end
        snap = o_regs;
        write_reg(6'h30, 8'h5a);
        `CHECK(o_regs, snap)
        i_gp_idx = 4'h0; i_gp_data = 8'ha5; i_gp_wr = 1'b1;
        @(negedge i_clk);
        i_gp_wr = 1'b0;
        read_gp(4'h0, 8'ha5);
        rst_req <= 1'b1;
        repeat (3) @(negedge i_clk);
        check_reset_state();
        `CHECK(o_regs[23*8+3], 1'b1)
        read_gp(4'h0, 8'ha5);
        release_and_time(1'b1, 10, 3 + 41 * CYC);
        print_verdict();
    end
endmodule
